//--- rtl/ila_top.sv
`timescale 1ns/100ps
`include "ila_defs.svh"
module ila_top
    import ila_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    input  wire logic [1:0]  addr_select_low,
    input  wire logic [1:0]  addr_select_high,
    input  wire logic        conv_valid,
    input  wire logic [7:0]  conv_data,
    output logic             alert_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    ila_state_t  st_q;
    logic [3:0]  cnt_q;
    logic [7:0]  sh_q, ptr_q, upper_q, res_q;
    logic [7:0]  low_q, high_q, hyst_q, cfg_q;
    logic [1:0]  idx_q;
    logic        rw_q, half_q, ack_q, hs_q, fixed_q;
    logic        over_q, under_q, over_d, under_d;
    logic        i2c_we_q;
    logic [15:0] i2c_wd_q, i2c_wm_q;
    logic        wpend_q;
    logic [7:0]  widx_q;
    logic [15:0] wd_q, wm_q;
    logic        scl_p_q, sda_p_q;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [5:0] pins_s;
    logic       scl_s, sda_s;

    ila_sync #(.W(6)) ila_sync_i (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     ({addr_select_high, addr_select_low, scl_i, sda_i}),
        .rst_val (6'h3f),
        .dout    (pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    wire scl_rise = scl_s & ~scl_p_q;
    wire scl_fall = ~scl_s & scl_p_q;
    wire start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // Target address

    function automatic logic [1:0] sel_map(input logic [1:0] code);
        // Floating is the zero offset, so an open pin picks the base
        sel_map = (code == `ILA_SEL_GND) ? 2'h1 : (code == `ILA_SEL_SUP) ? 2'h2 : 2'h0;
    endfunction : sel_map

    wire [4:0] addr_hi  = `ILA_ADDR_HI + {3'h0, sel_map(pins_s[5:4])};
    wire [6:0] my_addr  = fixed_q ? `ILA_ADDR_FIXED
                                  : {addr_hi, sel_map(pins_s[3:2])};
    wire       addr_hit = (sh_q[7:1] == my_addr);
    wire       hs_code  = (sh_q[7:3] == `ILA_HS_CODE);

    ////////////////////////////////////////////////////////////////////////////
    // Register map

    wire alert_cond = over_q | under_q;

    function automatic logic reg_hit(input logic [7:0] i);
        reg_hit = (i <= `ILA_IDX_HYST) || (i == `ILA_IDX_CTRL) || (i == `ILA_IDX_INFO);
    endfunction : reg_hit

    function automatic logic one_byte(input logic [7:0] i);
        one_byte = (i == `ILA_IDX_STATUS) || (i == `ILA_IDX_CONFIG) || (i == `ILA_IDX_CTRL);
    endfunction : one_byte

    function automatic logic [15:0] rd_val(input logic [7:0] i);
        rd_val = 16'h0000;
        unique case (i)
            `ILA_IDX_RESULT: rd_val = {cfg_q[`ILA_CF_FLAG] & alert_cond,
                                       3'h0, res_q, 4'h0};
            `ILA_IDX_STATUS: rd_val = {14'h0, over_q, under_q};
            `ILA_IDX_CONFIG: rd_val = {8'h00, cfg_q};
            `ILA_IDX_LOW:    rd_val = {4'h0, low_q, 4'h0};
            `ILA_IDX_HIGH:   rd_val = {4'h0, high_q, 4'h0};
            `ILA_IDX_HYST:   rd_val = {4'h0, hyst_q, 4'h0};
            `ILA_IDX_CTRL:   rd_val = {15'h0, fixed_q};
            `ILA_IDX_INFO:   rd_val = {hs_q, ptr_q, my_addr};
            default:         rd_val = 16'h0000;
        endcase
    endfunction : rd_val

    // Procedural, so a register change reaches the read path without a pointer change
    logic [15:0] ptr_val;
    always_comb ptr_val = rd_val(ptr_q);
    wire [7:0]  tx_up   = one_byte(ptr_q) ? ptr_val[7:0] : ptr_val[15:8];
    wire [7:0]  tx_lo   = ptr_val[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // Shared write port; I2C has the port, an AXI write waits one cycle

    wire        wp_en   = i2c_we_q | wpend_q;
    wire [7:0]  wp_idx  = i2c_we_q ? ptr_q : widx_q;
    wire [15:0] wp_mask = i2c_we_q ? i2c_wm_q : wm_q;
    wire [15:0] wp_raw  = (i2c_we_q ? i2c_wd_q : wd_q) & wp_mask;
    logic [15:0] wp_old;
    always_comb wp_old = rd_val(wp_idx);
    wire [15:0] wp_eff  = wp_raw | (wp_old & ~wp_mask);
    wire        st_wr   = wp_en && (wp_idx == `ILA_IDX_STATUS);
    wire        clr_ov  = st_wr & wp_raw[`ILA_ST_OVER];
    wire        clr_un  = st_wr & wp_raw[`ILA_ST_UNDER];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_q   <= `ILA_RST_CFG;
            low_q   <= `ILA_RST_LOW;
            high_q  <= `ILA_RST_HIGH;
            hyst_q  <= `ILA_RST_HYST;
            fixed_q <= 1'b0;
        end
        else if (wp_en)
        begin
            unique case (wp_idx)
                `ILA_IDX_CONFIG: cfg_q   <= wp_eff[7:0] & `ILA_CF_MASK;
                `ILA_IDX_LOW:    low_q   <= wp_eff[11:4];
                `ILA_IDX_HIGH:   high_q  <= wp_eff[11:4];
                `ILA_IDX_HYST:   hyst_q  <= wp_eff[11:4];
                `ILA_IDX_CTRL:   fixed_q <= wp_eff[0];
                default:         ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Limit comparison; flags set or release only when a conversion completes, and clear on a status write

    wire       hold    = cfg_q[`ILA_CF_HOLD];
    wire       above   = conv_data > high_q;
    wire       below   = conv_data < low_q;
    wire       ov_rel  = ({1'b0, conv_data} + {1'b0, hyst_q}) < {1'b0, high_q};
    wire       un_rel  = {1'b0, conv_data} > ({1'b0, low_q} + {1'b0, hyst_q});

    always_comb
    begin
        over_d  = over_q & ~clr_ov;
        under_d = under_q & ~clr_un;
        // Set after clear, so a violating sample in the clear cycle survives
        if (conv_valid)
        begin
            if (above)
                over_d = 1'b1;
            else if (!hold && ov_rel)
                over_d = 1'b0;
            if (below)
                under_d = 1'b1;
            else if (!hold && un_rel)
                under_d = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            over_q  <= 1'b0;
            under_q <= 1'b0;
            res_q   <= 8'h00;
            alert_o <= 1'b1;
        end
        else
        begin
            over_q  <= over_d;
            under_q <= under_d;
            if (conv_valid)
                res_q <= conv_data;
            alert_o <= (cfg_q[`ILA_CF_PIN] && alert_cond) ? cfg_q[`ILA_CF_POL]
                                                          : ~cfg_q[`ILA_CF_POL];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-wire target

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= ST_IDLE;  cnt_q <= 4'h0;  sh_q <= 8'h00;  ptr_q <= 8'h00;
            upper_q <= 8'h00; idx_q <= 2'h0;  rw_q <= 1'b0;   half_q <= 1'b0;
            ack_q <= 1'b0;    hs_q <= 1'b0;   sda_oe <= 1'b0; sda_o <= 1'b0;
            i2c_we_q <= 1'b0; i2c_wd_q <= 16'h0000; i2c_wm_q <= 16'h0000;
            scl_p_q <= 1'b1;  sda_p_q <= 1'b1;
        end
        else
        begin
            scl_p_q  <= scl_s;
            sda_p_q  <= sda_s;
            i2c_we_q <= 1'b0;
            if (stop_ev)
            begin
                st_q   <= ST_IDLE;
                hs_q   <= 1'b0;
                sda_oe <= 1'b0;
            end
            else if (start_ev)
            begin
                // Restart keeps hs_q, so a high-speed session survives it
                st_q   <= ST_ADDR;
                cnt_q  <= 4'h0;
                sda_oe <= 1'b0;
            end
            else if (scl_rise)
            begin
                cnt_q <= cnt_q + 4'h1;
                if (st_q == ST_ADDR || st_q == ST_WR)
                    sh_q <= {sh_q[6:0], sda_s};
                if (st_q == ST_RACK)
                    ack_q <= ~sda_s;
            end
            else if (scl_fall)
            begin
                unique case (st_q)
                    ST_IDLE: ;
                    ST_ADDR:
                        if (cnt_q == 4'h8)
                        begin
                            cnt_q <= 4'h0;
                            if (addr_hit)
                            begin
                                sda_oe <= 1'b1;
                                rw_q   <= sh_q[0];
                                st_q   <= ST_AACK;
                            end
                            else
                            begin
                                // Master code or foreign address: stay released
                                hs_q <= hs_q | hs_code;
                                st_q <= ST_IDLE;
                            end
                        end
                    ST_AACK:
                    begin
                        cnt_q <= 4'h0;
                        if (rw_q)
                        begin
                            sda_oe <= ~tx_up[7];
                            sh_q   <= {tx_up[6:0], 1'b0};
                            half_q <= 1'b0;
                            st_q   <= ST_RD;
                        end
                        else
                        begin
                            sda_oe <= 1'b0;
                            idx_q  <= 2'h0;
                            st_q   <= ST_WR;
                        end
                    end
                    ST_WR:
                        if (cnt_q == 4'h8)
                        begin
                            sda_oe <= 1'b1;
                            cnt_q  <= 4'h0;
                            st_q   <= ST_WACK;
                            unique case (idx_q)
                                2'h0:
                                begin
                                    ptr_q <= sh_q;
                                    idx_q <= 2'h1;
                                end
                                2'h1:
                                begin
                                    upper_q <= sh_q;
                                    idx_q   <= 2'h2;
                                    if (one_byte(ptr_q))
                                    begin
                                        i2c_we_q <= 1'b1;
                                        i2c_wd_q <= {8'h00, sh_q};
                                        i2c_wm_q <= 16'h00ff;
                                    end
                                end
                                default:
                                begin
                                    // Further pairs rewrite the same register
                                    idx_q    <= 2'h1;
                                    i2c_we_q <= ~one_byte(ptr_q);
                                    i2c_wd_q <= {upper_q, sh_q};
                                    i2c_wm_q <= 16'hffff;
                                end
                            endcase
                        end
                    ST_WACK:
                    begin
                        sda_oe <= 1'b0;
                        cnt_q  <= 4'h0;
                        st_q   <= ST_WR;
                    end
                    ST_RD:
                        if (cnt_q == 4'h8)
                        begin
                            sda_oe <= 1'b0;
                            cnt_q  <= 4'h0;
                            st_q   <= ST_RACK;
                        end
                        else
                        begin
                            sda_oe <= ~sh_q[7];
                            sh_q   <= {sh_q[6:0], 1'b0};
                        end
                    ST_RACK:
                    begin
                        cnt_q <= 4'h0;
                        if (ack_q)
                        begin
                            // Upper and lower alternate; data sampled per byte
                            sda_oe <= half_q ? ~tx_up[7] : ~tx_lo[7];
                            sh_q   <= half_q ? {tx_up[6:0], 1'b0} : {tx_lo[6:0], 1'b0};
                            half_q <= ~half_q;
                            st_q   <= ST_RD;
                        end
                        else
                            st_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    wire aw_go = awvalid & wvalid & ~awready & ~bvalid & ~wpend_q;
    wire w_hs  = awready & awvalid & wvalid;
    wire ar_hs = arready & arvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b0;  wready <= 1'b0;   bvalid <= 1'b0;
            bresp <= `ILA_RESP_OKAY;            wpend_q <= 1'b0;
            widx_q <= 8'h00;  wd_q <= 16'h0000; wm_q <= 16'h0000;
            arready <= 1'b0;  rvalid <= 1'b0;   rdata <= 32'h0;
            rresp <= `ILA_RESP_OKAY;
        end
        else
        begin
            awready <= aw_go;
            wready  <= aw_go;
            if (w_hs)
            begin
                wpend_q <= 1'b1;
                widx_q  <= {2'h0, awaddr[7:2]};
                wd_q    <= wdata[15:0];
                wm_q    <= {{8{wstrb[1]}}, {8{wstrb[0]}}};
            end
            if (wpend_q && !i2c_we_q)
            begin
                wpend_q <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= reg_hit(widx_q) ? `ILA_RESP_OKAY : `ILA_RESP_SLV;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
            arready <= arvalid & ~arready & ~rvalid;
            if (ar_hs)
            begin
                rvalid <= 1'b1;
                rdata  <= {16'h0000, rd_val({2'h0, araddr[7:2]})};
                rresp  <= reg_hit({2'h0, araddr[7:2]}) ? `ILA_RESP_OKAY : `ILA_RESP_SLV;
            end
            else if (rvalid && rready)
                rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    wire addr_done = (st_q == ST_ADDR) && scl_fall && (cnt_q == 4'h8) && !start_ev && !stop_ev;

    chk_ack_on_match: assert property (addr_done && addr_hit |=> sda_oe && st_q == ST_AACK)
        else $error("own address not acknowledged");
    chk_nack_foreign: assert property (addr_done && !addr_hit |=> !sda_oe [*2])
        else $error("foreign address or master code acknowledged");
    chk_ptr_load: assert property ((st_q == ST_WR) && scl_fall && cnt_q == 4'h8 && idx_q == 2'h0
        && !start_ev && !stop_ev |=> ptr_q == $past(sh_q))
        else $error("pointer not loaded from first byte");
    chk_hs_enter: assert property (addr_done && !addr_hit && hs_code |=> hs_q)
        else $error("master code did not enter high speed");
    chk_hs_stop: assert property (stop_ev |=> !hs_q && st_q == ST_IDLE)
        else $error("stop did not end high speed");
    chk_over_set: assert property (conv_valid && conv_data > high_q |=> over_q)
        else $error("over flag not set");
    chk_under_set: assert property (conv_valid && conv_data < low_q |=> under_q)
        else $error("under flag not set");
    chk_w1c_over: assert property (clr_ov && !conv_valid |=> !over_q)
        else $error("over flag not cleared by write");
    chk_hold_keep: assert property (hold && over_q && !clr_ov && !wp_en |=> over_q)
        else $error("held over flag dropped");
    chk_quiet_flags: assert property (!conv_valid && !st_wr |=> $stable(over_q) && $stable(under_q))
        else $error("flag moved without conversion");
    chk_alert_pin: assert property (cfg_q[`ILA_CF_PIN] && alert_cond
        |=> alert_o == $past(cfg_q[`ILA_CF_POL]))
        else $error("alert output wrong level");
    chk_sda_low_only: assert property (sda_o == 1'b0)
        else $error("data line driven high");
    chk_idle_released: assert property (st_q == ST_IDLE |-> !sda_oe)
        else $error("data line held while idle");

endmodule : ila_top

//--- pkg/ila_defs.svh
`ifndef ILA_DEFS_SVH
`define ILA_DEFS_SVH

// Register indices; I2C pointer value, AXI byte address is index times four
`define ILA_IDX_RESULT 8'h00
`define ILA_IDX_STATUS 8'h01
`define ILA_IDX_CONFIG 8'h02
`define ILA_IDX_LOW    8'h03
`define ILA_IDX_HIGH   8'h04
`define ILA_IDX_HYST   8'h05
`define ILA_IDX_CTRL   8'h08
`define ILA_IDX_INFO   8'h09

// Field positions
`define ILA_ST_UNDER   0
`define ILA_ST_OVER    1
`define ILA_CF_POL     0
`define ILA_CF_PIN     2
`define ILA_CF_FLAG    3
`define ILA_CF_HOLD    4
`define ILA_CF_MASK    8'h1d
`define ILA_LIM_LSB    4
`define ILA_RES_MSB    15

// Reset values
`define ILA_RST_LOW    8'h00
`define ILA_RST_HIGH   8'hff
`define ILA_RST_HYST   8'h00
`define ILA_RST_CFG    8'h00

// Target addressing; select pins coded 00 ground, 01 floating, 10 supply
`define ILA_SEL_GND    2'h0
`define ILA_SEL_SUP    2'h2
`define ILA_ADDR_FIXED 7'h54
`define ILA_ADDR_HI    5'h14
`define ILA_HS_CODE    5'h01

`define ILA_RESP_OKAY  2'h0
`define ILA_RESP_SLV   2'h2

`endif

//--- pkg/ila_pkg.sv
package ila_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_AACK,
        ST_WR,
        ST_WACK,
        ST_RD,
        ST_RACK
    } ila_state_t;

endpackage : ila_pkg

//--- rtl/ila_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for pins from outside the aclk domain
module ila_sync
#(
    parameter int W = 1
)
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] din,
    input  wire logic [W-1:0] rst_val,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= rst_val;
            dout   <= rst_val;
        end
        else
        begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule : ila_sync

//--- verification/ila_ctl_model.sv
`timescale 1ns/100ps
module ila_ctl_model
(
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    ////////////////////////////////////////
    // Quarter steps of a 64 ns bus clock; clock stands high between frames
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        #16 scl = 1'b1;
        #16 r = sda;
        #16 scl = 1'b0;
        #16;
    endtask : bit_io
    // Also serves as repeated start
    task automatic start();
        // Step off the aclk edge that the bench returns on
        #1;
        sda_low = 1'b0;
        #16 scl = 1'b1;
        #16 sda_low = 1'b1;
        #16 scl = 1'b0;
        #16;
    endtask : start
    task automatic stop();
        sda_low = 1'b1;
        #16 scl = 1'b1;
        #16 sda_low = 1'b0;
        #32;
    endtask : stop
    // Master code goes out through this at the slow rate
    task automatic wbyte(input logic [7:0] v, output logic ack_n);
        for (int i = 7; i >= 0; i--) bit_io(v[i], ack_n);
        bit_io(1'b1, ack_n);
    endtask : wbyte
    // Last byte of a read answered with not-acknowledge
    task automatic rbyte(input logic nack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(nack, r);
    endtask : rbyte
endmodule : ila_ctl_model

//--- verification/test_ila_top.sv
`timescale 1ns/100ps
`include "ila_defs.svh"
module test_ila_top;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, conv_valid;
    logic        awready, wready, bvalid, arready, rvalid, sda_o, sda_oe, alert_o;
    logic        scl, sda_low, ack;
    logic [7:0]  awaddr, araddr, conv_data, d;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, sel_lo, sel_hi;
    int          mismatches, cmp_count, cyc;
    wire         sda = ~((sda_oe & ~sda_o) | sda_low);

    ila_top ila_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_select_low(sel_lo), .addr_select_high(sel_hi),
        .conv_valid(conv_valid), .conv_data(conv_data), .alert_o(alert_o));
    ila_ctl_model ila_ctl_model_i (.scl(scl), .sda_low(sda_low), .sda(sda));

    ////////////////////////////////////////
    always #2 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            conclude();
        end
    end
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, `ILA_RESP_OKAY);
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, e);
        chk(rresp, er);
    endtask : axr
    task automatic conv(input logic [7:0] v);
        @(posedge aclk);
        conv_data <= v;
        conv_valid <= 1'b1;
        @(posedge aclk);
        conv_valid <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : conv

    ////////////////////////////////////////
    initial
    begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, conv_valid} = 8'h00;
        {awaddr, araddr, conv_data, wdata} = 56'h0;
        {sel_hi, sel_lo} = 4'h2;
        {mismatches, cmp_count, cyc} = {32'h0, 32'h0, 32'h0};
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        axr(8'h10, 32'h0ff0, `ILA_RESP_OKAY);
        axr(8'h18, 32'h0, `ILA_RESP_SLV);
        // Selects ground and supply give 1010110
        ila_ctl_model_i.start();
        ila_ctl_model_i.wbyte(8'hac, ack); chk(ack, 0);
        ila_ctl_model_i.wbyte(8'h04, ack); chk(ack, 0);
        ila_ctl_model_i.wbyte(8'h0a, ack); chk(ack, 0);
        ila_ctl_model_i.wbyte(8'hb0, ack); chk(ack, 0);
        ila_ctl_model_i.stop();
        axr(8'h10, 32'h0ab0, `ILA_RESP_OKAY);
        ila_ctl_model_i.start();
        ila_ctl_model_i.wbyte(8'ha1, ack); chk(ack, 1);
        ila_ctl_model_i.stop();
        ila_ctl_model_i.start();
        ila_ctl_model_i.wbyte(8'h09, ack); chk(ack, 1);
        ila_ctl_model_i.start();
        ila_ctl_model_i.wbyte(8'had, ack); chk(ack, 0);
        ila_ctl_model_i.rbyte(1'b0, d); chk(d, 8'h0a);
        ila_ctl_model_i.rbyte(1'b0, d); chk(d, 8'hb0);
        ila_ctl_model_i.rbyte(1'b1, d); chk(d, 8'h0a);
        ila_ctl_model_i.stop();
        axw(8'h08, 32'h0c);
        axw(8'h0c, 32'h0100);
        conv(8'hab); axr(8'h04, 32'h0, `ILA_RESP_OKAY);
        conv(8'hac); chk(alert_o, 0);
        axr(8'h04, 32'h2, `ILA_RESP_OKAY);
        axr(8'h00, 32'h8ac0, `ILA_RESP_OKAY);
        conv(8'h50); axr(8'h04, 32'h0, `ILA_RESP_OKAY);
        conv(8'h05); axr(8'h04, 32'h1, `ILA_RESP_OKAY);
        axw(8'h04, 32'h1); axr(8'h04, 32'h0, `ILA_RESP_OKAY);
        conv(8'h05); axr(8'h04, 32'h1, `ILA_RESP_OKAY);
        axw(8'h14, 32'h0100);
        conv(8'h1c); axr(8'h04, 32'h1, `ILA_RESP_OKAY);
        conv(8'h21); axr(8'h04, 32'h0, `ILA_RESP_OKAY);
        conv(8'h05);
        axw(8'h08, 32'h1c);
        conv(8'hff); conv(8'h50); axr(8'h04, 32'h3, `ILA_RESP_OKAY);
        axw(8'h04, 32'h3); axr(8'h04, 32'h0, `ILA_RESP_OKAY);
        repeat (2) @(posedge aclk); chk(alert_o, 1);
        // Input moves with no conversion done; flags must stay clear
        conv_data <= 8'hff;
        repeat (4) @(posedge aclk);
        axr(8'h04, 32'h0, `ILA_RESP_OKAY);
        // Both selects floating; pointer-only write, restart, one-byte read
        sel_hi <= 2'h1;
        sel_lo <= 2'h1;
        repeat (4) @(posedge aclk);
        ila_ctl_model_i.start();
        ila_ctl_model_i.wbyte(8'ha0, ack); chk(ack, 0);
        ila_ctl_model_i.wbyte(8'h02, ack); chk(ack, 0);
        ila_ctl_model_i.start();
        ila_ctl_model_i.wbyte(8'ha1, ack); chk(ack, 0);
        ila_ctl_model_i.rbyte(1'b1, d); chk(d, 8'h1c);
        ila_ctl_model_i.stop();
        axw(8'h20, 32'h1);
        ila_ctl_model_i.start();
        ila_ctl_model_i.wbyte(8'ha0, ack); chk(ack, 1);
        ila_ctl_model_i.start();
        ila_ctl_model_i.wbyte(8'ha8, ack); chk(ack, 0);
        ila_ctl_model_i.stop();
        conclude();
    end
endmodule : test_ila_top
